// file: hw/cart_host.sv
// host end: register port, link clock divider and byte sequencer
`timescale 1ns/1ps
module cart_host
  import cart_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // software register port
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DATA_W-1:0] reg_rdata,
  // link to the cartridge
  cart_if.host_end link
);

  typedef enum logic [3:0] {
    H_IDLE = 4'b0000,
    H_CLEAR = 4'b0001,
    H_PULSE_HI = 4'b0010,
    H_PULSE_LO = 4'b0011,
    H_INC_LO = 4'b0100,
    H_LOAD_HI = 4'b0101,
    H_LOAD_LO = 4'b0110,
    H_SEL_HI = 4'b0111,
    H_SHIFT_HI = 4'b1000,
    H_SHIFT_LO = 4'b1001
  } hstate_e;

  function automatic field_e header_field(input logic [ADDR_W-1:0] a);
    logic [4:0] o;
    o = a[4:0];
    if (a >= ADDR_W'(HEADER_BYTES * HEADER_COUNT)) return FLD_DATA;
    else if (o < HDR_TYPE_OFS) return FLD_NAME;
    else if (o < HDR_START_OFS) return FLD_TYPE;
    else if (o < HDR_END_OFS) return FLD_START;
    else if (o < HDR_DATE_OFS) return FLD_END;
    else if (o < HDR_UNUSED_OFS) return FLD_DATE;
    else return FLD_UNUSED;
  endfunction

  hstate_e state_reg;
  logic [7:0] div_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [ADDR_W-1:0] cnt_reg;
  logic [ADDR_W-1:0] target_reg;
  logic [2:0] bits_reg;
  logic [BYTE_W-1:0] asm_reg;
  logic [BYTE_W-1:0] data_reg;
  logic power_reg;
  logic deleted_reg;
  logic dir_end_reg;
  err_e err_reg;
  field_e field_reg;
  logic sel_reg;
  logic ck_reg;
  logic sclr_n_reg;
  logic cclr_n_reg;
  logic tick;
  logic power_drop;
  logic present;
  logic cmd_wr;
  op_e op;
  logic [7:0] arg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {link.cartridge_sense_b, link.cartridge_sense_a, link.serial_data_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign present = (sync2_reg[1] == SENSE_A_PRESENT) && (sync2_reg[2] == SENSE_B_PRESENT);
  assign tick = (div_reg == 8'(HALF_CYC - 1));
  assign cmd_wr = reg_wr && (reg_addr == REG_CMD) && (state_reg == H_IDLE);
  assign op = op_e'(reg_wdata[CMD_OP_LSB +: 3]);
  assign arg = reg_wdata[CMD_ARG_LSB +: 8];
  assign power_drop = cmd_wr && (op == OP_POWER_OFF);

  // each link step lasts one half period of the made clock
  always_ff @(posedge clk) begin
    if (!rst_n || state_reg == H_IDLE || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= H_IDLE;
      power_reg <= 1'b0;
      err_reg <= ERR_NONE;
      cnt_reg <= '0;
      target_reg <= '0;
      bits_reg <= '0;
      asm_reg <= '0;
      data_reg <= '0;
      deleted_reg <= 1'b0;
      dir_end_reg <= 1'b0;
      field_reg <= FLD_NAME;
    end else begin
      unique case (state_reg)
        H_IDLE: begin
          if (cmd_wr) begin
            err_reg <= ERR_NONE;
            if (op == OP_POWER_ON) begin
              if (!present) begin
                err_reg <= ERR_NO_CART; // see R14
              end else begin
                power_reg <= 1'b1;
                target_reg <= '0;
                state_reg <= H_CLEAR; // see R9
              end
            end else if (op == OP_POWER_OFF) begin
              power_reg <= 1'b0; // see R13
              cnt_reg <= '0;
            end else if (op == OP_READ || op == OP_SEEK_RECORD) begin
              if (!power_reg) begin
                err_reg <= ERR_NOT_POWERED;
              end else if (op == OP_SEEK_RECORD && arg > 8'(RECORD_MAX)) begin
                err_reg <= ERR_BAD_RECORD; // see R19
              end else if (op == OP_SEEK_RECORD) begin
                // no direct load: clear, then step up one at a time
                target_reg <= ADDR_W'({arg[5:0], 5'h00}); // see R12 R16
                state_reg <= H_CLEAR;
              end else if (sel_reg) begin
                cnt_reg <= cnt_reg + 1'b1; // see R15
                state_reg <= H_INC_LO;
              end else begin
                state_reg <= H_LOAD_HI;
              end
            end
          end
        end
        H_CLEAR: if (tick) begin
          cnt_reg <= '0;
          state_reg <= (target_reg == '0) ? H_IDLE : H_PULSE_HI;
        end
        H_PULSE_HI: if (tick) begin
          cnt_reg <= cnt_reg + 1'b1;
          state_reg <= H_PULSE_LO;
        end
        H_PULSE_LO: if (tick) begin
          state_reg <= (cnt_reg == target_reg) ? H_IDLE : H_PULSE_HI;
        end
        H_INC_LO: if (tick) state_reg <= H_LOAD_HI;
        H_LOAD_HI: if (tick) state_reg <= H_LOAD_LO;
        H_LOAD_LO: if (tick) state_reg <= H_SEL_HI;
        H_SEL_HI: if (tick) begin
          bits_reg <= '0;
          state_reg <= H_SHIFT_HI;
        end
        H_SHIFT_HI: if (tick) begin
          // sampled a full step after each load or shift edge
          asm_reg <= {asm_reg[BYTE_W-2:0], sync2_reg[0]};
          bits_reg <= bits_reg + 3'h1;
          if (bits_reg == 3'(SHIFTS_PER_BYTE)) begin // see R5
            data_reg <= {asm_reg[BYTE_W-2:0], sync2_reg[0]};
            field_reg <= header_field(cnt_reg); // see R18
            if (header_field(cnt_reg) != FLD_DATA && cnt_reg[4:0] == 5'h00) begin
              deleted_reg <= ({asm_reg[BYTE_W-2:0], sync2_reg[0]} == HDR_DELETED); // see R17
              dir_end_reg <= ({asm_reg[BYTE_W-2:0], sync2_reg[0]} == HDR_DIR_END);
            end
            state_reg <= H_IDLE;
          end else begin
            state_reg <= H_SHIFT_LO;
          end
        end
        H_SHIFT_LO: if (tick) state_reg <= H_SHIFT_HI;
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // link pins from flops, one cycle behind the state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_reg <= 1'b0;
      ck_reg <= 1'b0;
      sclr_n_reg <= 1'b0;
      cclr_n_reg <= 1'b0;
    end else begin
      ck_reg <= (state_reg == H_LOAD_HI) || (state_reg == H_SHIFT_HI);
      // power off takes the other pins low on the same edge as the power line
      sclr_n_reg <= power_reg && !power_drop && (state_reg != H_CLEAR);
      cclr_n_reg <= power_reg && !power_drop && (state_reg != H_CLEAR);
      if (!power_reg || power_drop || state_reg == H_CLEAR || state_reg == H_PULSE_LO ||
          state_reg == H_INC_LO) begin
        sel_reg <= 1'b0;
      end else if (state_reg == H_PULSE_HI || state_reg == H_SEL_HI) begin
        sel_reg <= 1'b1;
      end
    end
  end

  assign link.shift_load_select = sel_reg;
  assign link.shift_clock = ck_reg;
  assign link.shifter_clear_n = sclr_n_reg;
  assign link.counter_clear_n = cclr_n_reg;
  assign link.cartridge_power_on = power_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[ST_BUSY] <= (state_reg != H_IDLE);
          reg_rdata[ST_PRESENT] <= present;
          reg_rdata[ST_POWERED] <= power_reg;
          reg_rdata[ST_DELETED] <= deleted_reg;
          reg_rdata[ST_DIR_END] <= dir_end_reg;
          reg_rdata[ST_ERR_LSB +: 2] <= err_reg;
          reg_rdata[ST_FIELD_LSB +: 3] <= field_reg;
        end
        REG_DATA: reg_rdata <= REG_DATA_W'(data_reg);
        REG_POS: reg_rdata <= REG_DATA_W'(cnt_reg);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// file: hw/cart_pkg.sv
// shared constants and types for the serial rom cartridge link
package cart_pkg;

  // address counter and rom sizes
  localparam int ADDR_W = 14;
  localparam int ROM_BYTES_MIN = 2048;
  localparam int ROM_BYTES_MAX = 16384;
  localparam int BYTE_W = 8;
  localparam int SHIFTS_PER_BYTE = 7;

  // directory layout
  localparam int HEADER_BYTES = 32;
  localparam int HEADER_COUNT = 32;
  localparam int RECORD_MAX = 63;
  localparam logic [7:0] HDR_DELETED = 8'h00;
  localparam logic [7:0] HDR_DIR_END = 8'hff;
  localparam logic [4:0] HDR_TYPE_OFS = 5'h08;
  localparam logic [4:0] HDR_START_OFS = 5'h10;
  localparam logic [4:0] HDR_END_OFS = 5'h14;
  localparam logic [4:0] HDR_DATE_OFS = 5'h18;
  localparam logic [4:0] HDR_UNUSED_OFS = 5'h1e;

  // presence pattern on the two sense lines
  localparam logic SENSE_A_PRESENT = 1'b0;
  localparam logic SENSE_B_PRESENT = 1'b1;

  // timing: the host derives the link clock from its own clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int LINK_HALF_CYC_RAW = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int LINK_HALF_CYC = (LINK_HALF_CYC_RAW < 1) ? 1 : LINK_HALF_CYC_RAW;

  // host register map
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 16;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_POS = 4'h3;

  // command and status fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ARG_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_PRESENT = 1;
  localparam int ST_POWERED = 2;
  localparam int ST_DELETED = 3;
  localparam int ST_DIR_END = 4;
  localparam int ST_ERR_LSB = 8;
  localparam int ST_FIELD_LSB = 12;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_POWER_ON = 3'b001,
    OP_POWER_OFF = 3'b010,
    OP_READ = 3'b011,
    OP_SEEK_RECORD = 3'b100
  } op_e;

  typedef enum logic [1:0] {
    ERR_NONE = 2'b00,
    ERR_NO_CART = 2'b01,
    ERR_BAD_RECORD = 2'b10,
    ERR_NOT_POWERED = 2'b11
  } err_e;

  typedef enum logic [2:0] {
    FLD_NAME = 3'b000,
    FLD_TYPE = 3'b001,
    FLD_START = 3'b010,
    FLD_END = 3'b011,
    FLD_DATE = 3'b100,
    FLD_UNUSED = 3'b101,
    FLD_DATA = 3'b110
  } field_e;

endpackage

// file: hw/cart_if.sv
// pins between the cartridge and the host processors
`timescale 1ns/1ps
interface cart_if;
  logic serial_data_in;
  logic shift_load_select;
  logic shift_clock;
  logic shifter_clear_n;
  logic cartridge_power_on;
  logic counter_clear_n;
  logic cartridge_sense_a;
  logic cartridge_sense_b;

  modport device_end (
    output serial_data_in,
    output cartridge_sense_a,
    output cartridge_sense_b,
    input shift_load_select,
    input shift_clock,
    input shifter_clear_n,
    input cartridge_power_on,
    input counter_clear_n
  );

  modport host_end (
    input serial_data_in,
    input cartridge_sense_a,
    input cartridge_sense_b,
    output shift_load_select,
    output shift_clock,
    output shifter_clear_n,
    output cartridge_power_on,
    output counter_clear_n
  );
endinterface

// file: hw/cart_device.sv
// cartridge end: rom array, address counter and serial shift register
//
// Overview of operation
// R1: select falling edge increments the address counter
// R2: select low, clock rising loads the rom byte
// R3: msb of a loaded byte appears first
// R4: select high, clock falling shifts one bit
// R5: host shifts seven times, sampling eight bits
// R6: shifter clear low holds shift register cleared
// R7: counter clear low holds counter at zero
// R8: cartridge powered only while power line high
// R9: applying power resets the counter to zero
// R10: after clear, data reads 0, tape attached 1
// R11: rom sizes from 2K to 16K bytes
// R12: counter only clears or increments, no load
// R13: host removes power once reading is done
// R14: host checks both sense lines before reading
// R15: host reads addresses strictly in increasing order
// R16: rom starts with 32 headers of 32 bytes
// R17: header first byte 00 deleted, ff ends
// R18: header fields name, type, start, end, date
// R19: directory record numbers 0 to 63 only
// R20: fourteen bit counter wrapping past its maximum
`timescale 1ns/1ps
module cart_device
  import cart_pkg::*;
#(
  parameter int ROM_BYTES = ROM_BYTES_MAX
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to the host
  cart_if.device_end link,
  // rom programming port
  input wire logic prog_we,
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic [BYTE_W-1:0] prog_data,
  // tape drive strap, from a pin
  input wire logic tape_attached,
  // observation
  output logic powered,
  output logic [ADDR_W-1:0] rom_addr
);

  localparam int IDX_W = $clog2(ROM_BYTES);
  localparam int NSYNC = 6;
  localparam int S_SEL = 0;
  localparam int S_CK = 1;
  localparam int S_SCLR = 2;
  localparam int S_PWR = 3;
  localparam int S_CCLR = 4;
  localparam int S_TAPE = 5;

  logic [BYTE_W-1:0] rom_mem [ROM_BYTES];
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] prev_reg;
  logic [ADDR_W-1:0] count_reg;
  logic [BYTE_W-1:0] rom_q_reg;
  logic [BYTE_W-1:0] shift_reg;
  logic cleared_reg;
  logic sel_fall;
  logic ck_rise;
  logic ck_fall;
  logic pwr_rise;
  logic pwr_on;
  logic shifter_hold;
  logic counter_hold;

  // every pin passes two flops before use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= {tape_attached, link.counter_clear_n, link.cartridge_power_on,
                    link.shifter_clear_n, link.shift_clock, link.shift_load_select};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign pwr_on = sync2_reg[S_PWR]; // see R8
  assign pwr_rise = sync2_reg[S_PWR] && !prev_reg[S_PWR];
  assign sel_fall = !sync2_reg[S_SEL] && prev_reg[S_SEL];
  assign ck_rise = sync2_reg[S_CK] && !prev_reg[S_CK];
  assign ck_fall = !sync2_reg[S_CK] && prev_reg[S_CK];
  assign shifter_hold = !pwr_on || !sync2_reg[S_SCLR]; // see R6
  assign counter_hold = !pwr_on || !sync2_reg[S_CCLR] || pwr_rise; // see R7 R9

  // address counter: clear or count up, nothing else
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (counter_hold) begin
      count_reg <= '0; // see R7 R9 R12
    end else if (sel_fall) begin
      // full width wrap back to zero
      count_reg <= count_reg + 1'b1; // see R1 R20
    end
  end

  // rom array; addresses beyond the fitted size mirror
  always_ff @(posedge clk) begin
    if (prog_we) begin
      rom_mem[prog_addr[IDX_W-1:0]] <= prog_data;
    end
  end

  // counter settles a whole link step before any load edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rom_q_reg <= '0;
    end else if (!pwr_on) begin
      rom_q_reg <= '0;
    end else begin
      rom_q_reg <= rom_mem[count_reg[IDX_W-1:0]]; // see R11
    end
  end

  // parallel in, serial out, msb leading
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_reg <= '0;
      cleared_reg <= 1'b1;
    end else if (shifter_hold) begin
      shift_reg <= '0; // see R6
      cleared_reg <= 1'b1;
    end else if (!sync2_reg[S_SEL] && ck_rise) begin
      shift_reg <= rom_q_reg; // see R2
      cleared_reg <= 1'b0;
    end else if (sync2_reg[S_SEL] && ck_fall) begin
      shift_reg <= {shift_reg[BYTE_W-2:0], 1'b0}; // see R4
    end
  end

  // a cleared shifter lets the tape strap show through
  assign link.serial_data_in = !pwr_on ? 1'b0 :
                               cleared_reg ? sync2_reg[S_TAPE] : shift_reg[BYTE_W-1]; // see R3 R10

  // fixed presence pattern, readable whether powered or not
  assign link.cartridge_sense_a = SENSE_A_PRESENT;
  assign link.cartridge_sense_b = SENSE_B_PRESENT;

  assign powered = pwr_on;
  assign rom_addr = count_reg;

endmodule

// file: tb/cart_monitor.sv
// concurrent checks on the link between host and cartridge
`timescale 1ns/1ps
module cart_monitor
  import cart_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic serial_data_in,
  input wire logic shift_load_select,
  input wire logic shift_clock,
  input wire logic shifter_clear_n,
  input wire logic cartridge_power_on,
  input wire logic counter_clear_n,
  input wire logic cartridge_sense_a,
  input wire logic cartridge_sense_b,
  // cartridge side
  input wire logic tape_attached,
  input wire logic powered,
  input wire logic [ADDR_W-1:0] rom_addr
);
  logic [ADDR_W-1:0] next_addr_reg;
  logic [3:0] high_cnt_reg;

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // counter value a select fall must lead to
  always_ff @(posedge clk) begin
    if ($fell(shift_load_select)) begin
      next_addr_reg <= rom_addr + 1'b1;
    end
  end

  // clock highs in one shift phase; select fall restarts the count
  always_ff @(posedge clk) begin
    if (!rst_n || $fell(shift_load_select)) begin
      high_cnt_reg <= 4'h0;
    end else if ($rose(shift_clock) && shift_load_select) begin
      high_cnt_reg <= high_cnt_reg + 4'h1;
    end
  end

  a_count_on_fall: assert property (
    $fell(shift_load_select) && powered && counter_clear_n
    |-> ##[2:6] rom_addr == next_addr_reg) else $error("counter missed a select fall");
  a_clear_holds: assert property (
    !counter_clear_n [*6] |-> rom_addr == '0) else $error("counter not held at zero");
  a_unpowered_quiet: assert property (
    !cartridge_power_on [*6] |-> !serial_data_in && !powered) else $error("unpowered activity");
  a_power_follows: assert property (
    $rose(cartridge_power_on) |-> ##[1:5] powered) else $error("power not applied");
  a_power_zeroes: assert property (
    $rose(powered) |-> ##[0:2] rom_addr == '0) else $error("counter not zero at power up");
  a_link_off_idle: assert property (
    !cartridge_power_on |-> !shift_clock && !shift_load_select && !counter_clear_n
    && !shifter_clear_n) else $error("link active while power off");
  a_clock_high: assert property (
    $rose(shift_clock) |-> shift_clock [*4]) else $error("short link clock high");
  a_eight_samples: assert property (
    $fell(shift_load_select) |-> high_cnt_reg == 4'h0 || high_cnt_reg == 4'h8)
    else $error("wrong number of shift clocks");
  a_clear_gives_tape: assert property (
    $rose(shifter_clear_n) && cartridge_power_on |-> ##3 serial_data_in == tape_attached)
    else $error("cleared shifter gives wrong bit");
  a_sense_fixed: assert property (
    cartridge_sense_a == SENSE_A_PRESENT && cartridge_sense_b == SENSE_B_PRESENT)
    else $error("sense pattern wrong");
endmodule

// file: tb/tb_serial_rom_cartridge_reader.sv
// bench joining host and cartridge over the link, checked through the register port
`timescale 1ns/1ps
module tb_serial_rom_cartridge_reader;
  import cart_pkg::*;
  localparam int ROM_N = ROM_BYTES_MIN;
  typedef struct packed {logic [15:0] val; logic [15:0] mask;} note_s;
  logic clk, rst_n, reg_wr, reg_rd, prog_we, tape_attached, powered, chk, rd_q, chk_q;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [REG_DATA_W-1:0] reg_wdata, reg_rdata;
  logic [ADDR_W-1:0] prog_addr, rom_addr;
  logic [BYTE_W-1:0] prog_data;
  logic [7:0] rom_img [ROM_N];
  note_s notes [$];
  int n_errors = 0;
  int comparisons = 0;

  cart_if link ();
  cart_device #(.ROM_BYTES(ROM_N)) i_cart_device (.clk(clk), .rst_n(rst_n), .link(link),
    .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
    .tape_attached(tape_attached), .powered(powered), .rom_addr(rom_addr));
  cart_host i_cart_host (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
  cart_monitor i_cart_monitor (.clk(clk), .rst_n(rst_n), .serial_data_in(link.serial_data_in),
    .shift_load_select(link.shift_load_select), .shift_clock(link.shift_clock),
    .shifter_clear_n(link.shifter_clear_n), .cartridge_power_on(link.cartridge_power_on),
    .counter_clear_n(link.counter_clear_n), .cartridge_sense_a(link.cartridge_sense_a),
    .cartridge_sense_b(link.cartridge_sense_b), .tape_attached(tape_attached),
    .powered(powered), .rom_addr(rom_addr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check_reg(input note_s n, input logic [15:0] got);
    comparisons++;
    if (((got ^ n.val) & n.mask) !== 16'h0) begin
      n_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, n.val & n.mask, got & n.mask);
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q === 1'b1 && chk_q === 1'b1) check_reg(notes.pop_front(), reg_rdata);
    rd_q <= reg_rd;
    chk_q <= chk;
  end

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_read(input logic [3:0] a, input logic do_chk, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    chk <= do_chk;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask

  task automatic expect_reg(input logic [3:0] a, input logic [15:0] val, input logic [15:0] m);
    logic [15:0] v;
    notes.push_back({val, m});
    reg_read(a, 1'b1, v);
  endtask

  // a seek to the last record takes about sixteen thousand cycles
  task automatic wait_idle();
    logic [15:0] v;
    v = 16'h0001;
    for (int i = 0; i < 20000 && v[ST_BUSY] !== 1'b0; i++) reg_read(REG_STATUS, 1'b0, v);
    if (v[ST_BUSY] !== 1'b0) begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic cmd(input op_e op, input logic [7:0] arg);
    reg_write(REG_CMD, {arg, 5'h00, op});
    wait_idle();
  endtask

  task automatic read_byte(input int a);
    logic [15:0] st, m;
    int o;
    o = a % HEADER_BYTES;
    st = 16'h0006;
    m = 16'h7307;
    if (a >= HEADER_COUNT * HEADER_BYTES) st[14:12] = FLD_DATA;
    else if (o < HDR_TYPE_OFS) st[14:12] = FLD_NAME;
    else if (o < HDR_START_OFS) st[14:12] = FLD_TYPE;
    else if (o < HDR_END_OFS) st[14:12] = FLD_START;
    else if (o < HDR_DATE_OFS) st[14:12] = FLD_END;
    else if (o < HDR_UNUSED_OFS) st[14:12] = FLD_DATE;
    else st[14:12] = FLD_UNUSED;
    if (o == 0 && a < HEADER_COUNT * HEADER_BYTES) begin
      st[ST_DELETED] = (rom_img[a] == HDR_DELETED);
      st[ST_DIR_END] = (rom_img[a] == HDR_DIR_END);
      m[4:3] = 2'b11;
    end
    cmd(OP_READ, 8'h00);
    expect_reg(REG_DATA, {8'h00, rom_img[a % ROM_N]}, 16'h00ff);
    expect_reg(REG_POS, a[15:0], 16'h3fff);
    expect_reg(REG_STATUS, st, m);
  endtask

  initial begin
    int n;
    {rst_n, reg_wr, reg_rd, prog_we, tape_attached, chk} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    prog_addr = '0;
    prog_data = '0;
    n = $urandom(82852);
    foreach (rom_img[i]) rom_img[i] = 8'($urandom);
    rom_img[0] = HDR_DIR_END;
    rom_img[HEADER_BYTES] = HDR_DELETED;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    prog_we <= 1'b1;
    for (int a = 0; a < ROM_N; a++) begin
      prog_addr <= 14'(a);
      prog_data <= rom_img[a];
      @(posedge clk);
    end
    prog_we <= 1'b0;
    @(posedge clk);
    expect_reg(REG_STATUS, 16'h0000, 16'h0305);
    expect_reg(4'hf, 16'h0000, 16'hffff);
    for (int t = 0; t < 2; t++) begin
      tape_attached <= t[0];
      cmd(OP_POWER_ON, 8'h00);
      for (int a = 0; a <= HEADER_BYTES; a++) read_byte(a);
      n = 1 + $urandom_range(61);
      cmd(OP_SEEK_RECORD, 8'(n));
      read_byte(n * HEADER_BYTES);
      read_byte(n * HEADER_BYTES + 1);
      cmd(OP_POWER_OFF, 8'h00);
      expect_reg(REG_STATUS, 16'h0000, 16'h0004);
    end
    cmd(OP_POWER_ON, 8'h00);
    cmd(OP_SEEK_RECORD, 8'(RECORD_MAX + 1));
    expect_reg(REG_STATUS, {6'h00, ERR_BAD_RECORD, 8'h04}, 16'h0304);
    // power off while busy must be ignored
    reg_write(REG_CMD, {8'(RECORD_MAX), 5'h00, OP_SEEK_RECORD});
    reg_write(REG_CMD, {8'h00, 5'h00, OP_POWER_OFF});
    wait_idle();
    read_byte(RECORD_MAX * HEADER_BYTES);
    cmd(OP_POWER_OFF, 8'h00);
    cmd(OP_READ, 8'h00);
    expect_reg(REG_STATUS, {6'h00, ERR_NOT_POWERED, 8'h00}, 16'h0304);
    end_of_test();
  end
endmodule
